// file: hw/tcp_map.svh
// Register indices, field positions, reset values and boundaries of the timer
`ifndef TCP_MAP_SVH
`define TCP_MAP_SVH
`define TCP_IDX_RELOAD 8'hCD
`define TCP_IDX_MODE 8'hDA
`define TCP_IDX_COUNT 8'hDB
`define TCP_IDX_IRQ_STAT 8'hE0
`define TCP_IDX_IRQ_EN 8'hE1
`define TCP_IDX_IRQ_CLR 8'hE2
`define TCP_BIT_EN 7
`define TCP_RATE_HI 6
`define TCP_RATE_LO 4
`define TCP_BIT_CKS 3
`define TCP_BIT_ALOAD 2
`define TCP_BIT_TOUT 1
`define TCP_BIT_PWM 0
`define TCP_ST_OVF 0
`define TCP_ST_EVT 1
`define TCP_ST_W 2
`define TCP_RST8 8'h00
`define TCP_TOP_256 8'hFF
`define TCP_TOP_64 8'h3F
`define TCP_TOP_32 8'h1F
`define TCP_TOP_16 8'h0F
`define TCP_CNT_STEP 8'h01
`endif

// file: hw/tcp_pkg.sv
// Types shared by the timer files
package tcp_pkg;
  typedef logic [7:0] tcp_byte_t;
  typedef enum logic [1:0] {
    TCP_BUS_IDLE = 2'b00,
    TCP_BUS_ACK = 2'b01
  } tcp_bus_state_t;
endpackage

// file: hw/tcp_tick_gen.sv
// Prescaler and event pin synchroniser with falling edge detect
`timescale 1ns/1ns
`default_nettype none
module tcp_tick_gen
  import tcp_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [2:0] rate,
  input wire logic event_input_pin,
  output logic presc_tick,
  output logic ev_fall,
  output logic ev_level
);
  logic [WIDTH-1:0] div_r, div_nxt, mask;
  logic s1_r, s2_r, s3_r;
  logic lvl_r, lvl_nxt, fall_r, fall_nxt;

  always_comb begin
    div_nxt = div_r + {{(WIDTH-1){1'b0}}, 1'b1};
    // Divide by 2 to the power (8 minus rate)
    mask = {WIDTH{1'b1}} >> rate;
    // Level accepted only when second and third stages agree
    lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
    fall_nxt = lvl_r & ~lvl_nxt;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      div_r <= '0;
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      lvl_r <= 1'b1;
      fall_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      s1_r <= event_input_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
      fall_r <= fall_nxt;
    end
  end

  assign presc_tick = ((div_r & mask) == mask);
  assign ev_fall = fall_r;
  assign ev_level = lvl_r;

  one_fall_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ev_fall |=> !ev_fall) else $error("falling edge pulse longer than one cycle");
endmodule
`default_nettype wire

// file: hw/tcp_timer.sv
// Timer/counter with reload, toggle and PWM output on an Avalon-MM slave
// Function
// - Non-PWM overflow is all-ones to zero
// - Overflow keeps counting and raises request flag
// - External source counts each falling edge
// - Mode bit 3 selects internal or external
// - External source ignores prescale, event flag zero
// - Prescale divides by two to (8-code)
// - Enable bit 7 gates counting and outputs
// - Bit 0 drives PWM onto shared pin
// - Bit 1 routes toggle signal to pin
// - Bit 2 enables reload outside PWM
// - Reload copies buffered value into count
// - Reload writes buffered until next overflow
// - PWM mode never reloads, count restarts at zero
// - PWM bit pair picks boundary 256/64/32/16
// - Interval is boundary minus start, clocks
// - PWM high while count below reload
// - Toggle output inverts every overflow
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "tcp_map.svh"
module tcp_timer
  import tcp_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic event_input_pin,
  input wire logic gpio_o,
  input wire logic gpio_oe,
  output logic shared_output_pin_o,
  output logic shared_output_pin_oe,
  output logic irq
);
  // Bus slave state
  tcp_bus_state_t bus_r, bus_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  tcp_byte_t idx;
  logic wr_go, wr_lane;
  // Timer state
  tcp_byte_t mode_r, mode_nxt;
  tcp_byte_t count_r, count_nxt;
  tcp_byte_t hold_r, hold_nxt;
  tcp_byte_t active_r, active_nxt;
  logic tog_r, tog_nxt;
  logic pwm_r, pwm_nxt;
  logic pin_r, pin_nxt;
  logic pin_oe_r, pin_oe_nxt;
  logic [`TCP_ST_W-1:0] stat_r, stat_nxt;
  logic [`TCP_ST_W-1:0] ien_r, ien_nxt;
  logic [`TCP_ST_W-1:0] clr_bits;
  // Decoded mode fields
  logic en, cks, aload, tout, pwm_en, pwm_mode, reload_on;
  logic [2:0] rate;
  logic presc_tick, ev_fall, ev_level, tick, ovf;
  tcp_byte_t top;
  logic wr_count;

  tcp_tick_gen #(
    .WIDTH(8)
  ) u_tick (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .rate(rate),
    .event_input_pin(event_input_pin),
    .presc_tick(presc_tick),
    .ev_fall(ev_fall),
    .ev_level()
  );
  assign ev_level = 1'b0;

  assign en = mode_r[`TCP_BIT_EN];
  assign cks = mode_r[`TCP_BIT_CKS];
  assign aload = mode_r[`TCP_BIT_ALOAD];
  assign tout = mode_r[`TCP_BIT_TOUT];
  assign pwm_en = mode_r[`TCP_BIT_PWM];
  assign rate = mode_r[`TCP_RATE_HI:`TCP_RATE_LO];
  // External source uses the full 256 boundary
  assign pwm_mode = pwm_en & ~cks;

  // Avalon slave: one wait cycle, then answer
  assign idx = avs_address[ADDR_W-1:2];
  assign wr_go = avs_write & (bus_r == TCP_BUS_ACK);
  assign wr_lane = wr_go & avs_byteenable[0];
  assign wr_count = wr_lane & (idx == `TCP_IDX_COUNT);
  assign avs_waitrequest = (avs_read | avs_write) & (bus_r != TCP_BUS_ACK);
  assign avs_readdata = rdata_r;

  always_comb begin
    bus_nxt = TCP_BUS_IDLE;
    rdata_nxt = rdata_r;
    case (bus_r)
      TCP_BUS_IDLE: begin
        if (avs_read | avs_write) begin
          bus_nxt = TCP_BUS_ACK;
        end
        if (avs_read) begin
          rdata_nxt = 32'h00000000;
          case (idx)
            `TCP_IDX_MODE: rdata_nxt[7:0] = mode_r;
            `TCP_IDX_COUNT: rdata_nxt[7:0] = count_r;
            `TCP_IDX_IRQ_STAT: rdata_nxt[`TCP_ST_W-1:0] = stat_r;
            `TCP_IDX_IRQ_EN: rdata_nxt[`TCP_ST_W-1:0] = ien_r;
            default: rdata_nxt = 32'h00000000;
          endcase
        end
      end
      TCP_BUS_ACK: bus_nxt = TCP_BUS_IDLE;
      default: bus_nxt = TCP_BUS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bus_r <= TCP_BUS_IDLE;
      rdata_r <= 32'h00000000;
    end else begin
      bus_r <= bus_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Counting engine
  always_comb begin
    // Internal ticks only count when the internal source is chosen
    tick = en & (cks ? ev_fall : presc_tick);
    case ({aload, tout})
      2'b00: top = `TCP_TOP_256;
      2'b01: top = `TCP_TOP_64;
      2'b10: top = `TCP_TOP_32;
      2'b11: top = `TCP_TOP_16;
      default: top = `TCP_TOP_256;
    endcase
    if (!pwm_mode) begin
      top = `TCP_TOP_256;
    end
    // Low bits matching the boundary mark the last count before wrap
    ovf = tick & ((count_r & top) == top);
    // PWM reload is the duty compare, so the count restarts at zero each period
    reload_on = aload & ~pwm_mode;
  end

  always_comb begin
    mode_nxt = mode_r;
    count_nxt = count_r;
    hold_nxt = hold_r;
    active_nxt = active_r;
    tog_nxt = tog_r;
    pwm_nxt = pwm_r;
    if (ovf) begin
      active_nxt = hold_r;
      tog_nxt = ~tog_r;
      if (reload_on) begin
        // New buffered value becomes active at this overflow and is loaded
        count_nxt = hold_r;
      end else begin
        count_nxt = `TCP_RST8;
      end
    end else if (tick) begin
      count_nxt = count_r + `TCP_CNT_STEP;
    end
    if (en & pwm_mode) begin
      pwm_nxt = (count_r < active_r);
    end
    // Software writes win over counting in the same cycle
    if (wr_lane) begin
      case (idx)
        `TCP_IDX_MODE: mode_nxt = avs_writedata[7:0];
        `TCP_IDX_COUNT: count_nxt = avs_writedata[7:0];
        `TCP_IDX_RELOAD: hold_nxt = avs_writedata[7:0];
        default: mode_nxt = mode_r;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mode_r <= `TCP_RST8;
      count_r <= `TCP_RST8;
      hold_r <= `TCP_RST8;
      active_r <= `TCP_RST8;
      tog_r <= 1'b0;
      pwm_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      count_r <= count_nxt;
      hold_r <= hold_nxt;
      active_r <= active_nxt;
      tog_r <= tog_nxt;
      pwm_r <= pwm_nxt;
    end
  end

  // Shared pin mux, registered so the pin never glitches on mode writes
  always_comb begin
    if (pwm_en) begin
      pin_nxt = pwm_r;
      pin_oe_nxt = 1'b1;
    end else if (tout) begin
      pin_nxt = tog_r;
      pin_oe_nxt = 1'b1;
    end else begin
      pin_nxt = gpio_o;
      pin_oe_nxt = gpio_oe;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_r <= 1'b0;
      pin_oe_r <= 1'b0;
    end else begin
      pin_r <= pin_nxt;
      pin_oe_r <= pin_oe_nxt;
    end
  end

  assign shared_output_pin_o = pin_r;
  assign shared_output_pin_oe = pin_oe_r;

  // Interrupt status: set beats clear in the same cycle
  always_comb begin
    clr_bits = '0;
    if (wr_lane & (idx == `TCP_IDX_IRQ_CLR)) begin
      clr_bits = avs_writedata[`TCP_ST_W-1:0];
    end
    stat_nxt = stat_r & ~clr_bits;
    ien_nxt = ien_r;
    if (wr_lane & (idx == `TCP_IDX_IRQ_EN)) begin
      ien_nxt = avs_writedata[`TCP_ST_W-1:0];
    end
    if (ovf) begin
      stat_nxt[`TCP_ST_OVF] = 1'b1;
    end
    if (ev_fall & ~cks) begin
      stat_nxt[`TCP_ST_EVT] = 1'b1;
    end
    // Pin used as counter clock raises no pin request
    if (cks) begin
      stat_nxt[`TCP_ST_EVT] = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      stat_r <= '0;
      ien_r <= '0;
    end else begin
      stat_r <= stat_nxt;
      ien_r <= ien_nxt;
    end
  end

  assign irq = |(stat_r & ien_r);

  // Checks
  ovf_wrap_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (tick & !pwm_mode & !aload & (count_r == `TCP_TOP_256) & !wr_count)
    |=> (count_r == `TCP_RST8)) else $error("count did not wrap to zero");

  ovf_flag_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ovf |=> stat_r[`TCP_ST_OVF]) else $error("overflow flag not raised");

  ext_count_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (en & cks & ev_fall & !ovf & !wr_count)
    |=> (count_r == $past(count_r) + `TCP_CNT_STEP)) else $error("event not counted");

  ext_only_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (cks & !ev_fall & !wr_count) |=> $stable(count_r)) else $error("count moved without event");

  evt_zero_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    cks |=> !stat_r[`TCP_ST_EVT]) else $error("pin request set under external source");

  stop_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!en & !wr_count) |=> ($stable(count_r) && $stable(tog_r) && $stable(pwm_r)))
    else $error("timer ran while disabled");

  reload_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (ovf & reload_on & !wr_count) |=> (count_r == $past(hold_r)))
    else $error("reload value not loaded");

  pwm_wrap_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (ovf & pwm_mode & !wr_count) |=> (count_r == `TCP_RST8 && active_r == $past(hold_r)))
    else $error("pwm period did not restart");

  dbuf_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !ovf |=> $stable(active_r)) else $error("active reload changed without overflow");

  pwm_cmp_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (en & pwm_mode) |=> (pwm_r == ($past(count_r) < $past(active_r))))
    else $error("pwm level wrong");

  toggle_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ovf |=> (tog_r != $past(tog_r))) else $error("toggle did not invert");

  pin_pwm_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    pwm_en |=> (shared_output_pin_oe && shared_output_pin_o == $past(pwm_r)))
    else $error("pin not driven by pwm");

  bus_ack_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ($rose(avs_read) && bus_r == TCP_BUS_IDLE) |=> !avs_waitrequest)
    else $error("bus answer late");
endmodule
`default_nettype wire

// file: test/tcp_evt_src.sv
// Far-side model of the external event source on the event pin
`timescale 1ns/1ns
`default_nettype none
module tcp_evt_src (
  input wire logic go,
  input wire logic [7:0] n_edges,
  output logic event_input_pin
);
  // Idle high; each level held far longer than the pin synchroniser
  initial event_input_pin = 1'b1;
  always @(posedge go) begin
    repeat (n_edges) begin
      #73 event_input_pin = 1'b0;
      #91 event_input_pin = 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: test/tb_tcp_timer.sv
// Self-checking bench for the timer through its Avalon slave
`timescale 1ns/1ns
`default_nettype none
`include "tcp_map.svh"
module tb_tcp_timer;
  import tcp_pkg::*;
  logic sys_clk, resetn, avs_read, avs_write, avs_waitrequest, irq;
  logic gpio_o, gpio_oe, pin_o, pin_oe, ev_pin, ev_go;
  logic [9:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  int n_mismatch, n_compared, t;
  tcp_timer u_dut (.sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .event_input_pin(ev_pin), .gpio_o(gpio_o), .gpio_oe(gpio_oe),
    .shared_output_pin_o(pin_o), .shared_output_pin_oe(pin_oe), .irq(irq));
  tcp_evt_src u_src (.go(ev_go), .n_edges(8'h05), .event_input_pin(ev_pin));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic conclude;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic timeout(input string nm);
    n_mismatch++;
    $display("BAD %s expected done seen timeout", nm);
    conclude();
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    // Values read right after the edge are the ones the edge sampled
    do begin
      @(posedge sys_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    if (avs_waitrequest !== 1'b0) timeout("bus");
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] e, input string nm);
    bus(idx, 1'b0, 8'h00);
    chk(nm, e, q);
  endtask
  // Bounded wait for the interrupt line to rise
  task automatic wait_irq;
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 2000) begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 2000) timeout("irq_wait");
  endtask
  // Cycles the pin (or irq when sel) spends at level v after next entering it
  task automatic measure(input logic v, input logic sel);
    int k;
    k = 0;
    t = 0;
    while (((sel ? irq : pin_o) !== !v) && k < 2000) begin
      @(posedge sys_clk);
      k++;
    end
    while (((sel ? irq : pin_o) !== v) && k < 2000) begin
      @(posedge sys_clk);
      k++;
    end
    while (((sel ? irq : pin_o) === v) && k < 2000) begin
      @(posedge sys_clk);
      k++;
      t++;
    end
    if (k >= 2000) timeout("pin_wait");
  endtask
  initial begin
    resetn = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = '0;
    avs_writedata = '0;
    gpio_o = 1'b1;
    gpio_oe = 1'b1;
    ev_go = 1'b0;
    n_mismatch = 0;
    n_compared = 0;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(`TCP_IDX_MODE, 0, "mode_reset");
    rd(`TCP_IDX_COUNT, 0, "count_reset");
    bus(`TCP_IDX_RELOAD, 1'b1, 8'h55);
    rd(`TCP_IDX_RELOAD, 0, "reload_wo");
    rd(8'h10, 0, "unmapped");
    chk("gpio_pass", 2'b11, {pin_oe, pin_o});
    $display("test registers done");
    // Overflow without reload restarts from zero
    bus(`TCP_IDX_IRQ_EN, 1'b1, 8'h01);
    bus(`TCP_IDX_COUNT, 1'b1, 8'hFC);
    bus(`TCP_IDX_MODE, 1'b1, 8'hF0);
    wait_irq();
    chk("irq_high", 1, irq);
    bus(`TCP_IDX_MODE, 1'b1, 8'h70);
    rd(`TCP_IDX_IRQ_STAT, 1, "ovf_status");
    bus(`TCP_IDX_COUNT, 1'b0, 8'h00);
    chk("wrapped", 0, q[7:4]);
    t = q;
    rd(`TCP_IDX_COUNT, t, "frozen");
    bus(`TCP_IDX_IRQ_CLR, 1'b1, 8'h01);
    rd(`TCP_IDX_IRQ_STAT, 0, "cleared");
    chk("irq_low", 0, irq);
    $display("test overflow done");
    // Toggle half period is (256 - reload) ticks of 2^(8-rate) cycles
    bus(`TCP_IDX_RELOAD, 1'b1, 8'hF0);
    for (int r = 7; r >= 6; r--) begin
      bus(`TCP_IDX_MODE, 1'b1, {1'b1, 3'(r), 4'b0110});
      measure(1'b1, 1'b0);
      chk("toggle_half", 16 << (8 - r), t);
      chk("toggle_oe", 1, pin_oe);
    end
    $display("test toggle done");
    // PWM, boundary 16, duty 4 of 16
    bus(`TCP_IDX_RELOAD, 1'b1, 8'h04);
    bus(`TCP_IDX_MODE, 1'b1, 8'hF7);
    measure(1'b1, 1'b0);
    measure(1'b1, 1'b0);
    chk("pwm_high", 8, t);
    measure(1'b0, 1'b0);
    chk("pwm_low", 24, t);
    $display("test pwm done");
    // External events; prescale set but ignored
    bus(`TCP_IDX_MODE, 1'b1, 8'h70);
    bus(`TCP_IDX_IRQ_CLR, 1'b1, 8'h03);
    bus(`TCP_IDX_COUNT, 1'b1, 8'h00);
    bus(`TCP_IDX_MODE, 1'b1, 8'hF8);
    ev_go <= 1'b1;
    repeat (120) @(posedge sys_clk);
    rd(`TCP_IDX_COUNT, 5, "events");
    rd(`TCP_IDX_IRQ_STAT, 0, "evt_flag");
    $display("test events done");
    conclude();
  end
endmodule
`default_nettype wire
